// ---- rtl/esap_pkg.sv ----
// Purpose: Shared constants and types for the 2-wire slave address and protect block
// Assumes: 200 MHz system clock, one word address byte, 256-byte array
// Notes: Control register layout and its word address are local decisions

package esap_pkg;

   // -------------------------------------------------
   // Slave address byte layout
   // -------------------------------------------------
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_ZERO_POS = 3;
   localparam int SA_SEL_HI_POS = 2;
   localparam int SA_SEL_LO_POS = 1;
   localparam int SA_RW_POS = 0;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // -------------------------------------------------
   // Control register access
   // -------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hFF;
   localparam logic [7:0] CR_CLR_WEL = 8'h00;
   localparam logic [7:0] CR_SET_WEL = 8'h02;
   localparam logic [7:0] CR_SET_RWEL = 8'h06;
   localparam int CR_PEN_POS = 7;
   localparam int CR_WD_LSB = 5;
   localparam int CR_BP_LSB = 3;
   localparam logic [1:0] CR_RST_WD = 2'h3;
   localparam logic [1:0] CR_RST_BP = 2'h0;

   // -------------------------------------------------
   // Timing
   // -------------------------------------------------
   localparam int MCLK_MHZ = 200;
   localparam int PURST_MS = 250;
   localparam int WC_MAX_MS = 10;
   localparam int STBY_NS = 200;
   localparam int PURST_CYC = PURST_MS * MCLK_MHZ * 1000;
   localparam int WC_CYC = WC_MAX_MS * MCLK_MHZ * 1000;
   localparam int STBY_CYC = (STBY_NS * MCLK_MHZ + 999) / 1000;

   // -------------------------------------------------
   // Types
   // -------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h3,
      ST_WADDR = 4'h2,
      ST_WADDR_ACK = 4'h6,
      ST_WDATA = 4'h7,
      ST_WDATA_ACK = 4'h5,
      ST_RDATA = 4'h4,
      ST_RDATA_ACK = 4'hC,
      ST_IGNORE = 4'hD
   } esap_state_t;

   typedef struct packed {
      logic pen;
      logic [1:0] wd;
      logic [1:0] bp;
   } esap_cr_t;

   typedef struct packed {
      logic [1:0] scl_p;
      logic scl_q;
      logic [1:0] sda_p;
      logic sda_q;
      logic [1:0] wp_p;
      logic [1:0] s0_p;
      logic [1:0] s1_p;
      logic [1:0] rst_p;
      logic [1:0] busy_p;
      logic busy_q;
      esap_state_t state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] osh;
      logic ok;
      logic acked;
      logic oe;
      logic active;
      logic rw;
      logic [7:0] addr;
      logic pend;
      logic [7:0] wa;
      logic [7:0] wd;
      logic commit;
      logic launch_tgl;
      logic write_enable_latch;
      logic rwel;
      esap_cr_t cr;
   } esap_link_t;

   typedef struct packed {
      logic [1:0] launch_p;
      logic launch_q;
      logic [1:0] act_p;
      logic [31:0] por_cnt;
      logic rst_act;
      logic busy;
      logic [31:0] wc_cnt;
      logic [7:0] lin;
      logic stby;
   } esap_sys_t;

endpackage

// ---- rtl/esap_slave.sv ----
// Purpose: 2-wire slave front end: address decode, write protection, power states
// Assumes: SCL, SDA, WP and straps are asynchronous pins sampled on link_clk_i
// Notes: link_clk_i runs free and much faster than SCL; array kept in link domain
//
// How it works
// - Address byte continues with a zero bit, two select bits, then direction.
// - Direction bit one selects a read, zero selects a write.
// - Address byte is compared bar the direction bit; acknowledge only on a match.
// - Word address comes from master or the internal address counter.
// - Power-up leaves the block in standby with the data pin released.
// - Write enable latch clears at power-up; writes other than 00h and 02h to the control register are rejected while clear.
// - Supervisor reset output stays active for the power-up timeout.
// - Writes other than 00h and 02h to the control register are accepted only while the write enable latch is set.
// - A write cycle starts at stop only after whole bytes and acknowledges.
// - Control register writes need the three-step enable sequence first.
// - Write-protect pin high with pin enable bit set blocks control writes.
// - Active supervisor reset ignores bus traffic and aborts transfers.
// - Writes into array regions marked protected are refused.
// - Active on start; standby after bad select, after stop, or write cycle.
// - No address acknowledge while a write cycle is in progress.
// - Self-timed write cycle ends within ten milliseconds of the stop.
// - Power-up reset timeout is 250 ms, within 100 to 400 ms.

`timescale 1ns/1ps

module esap_slave #(
   parameter logic [3:0] DEV_TYPE_ID = 4'h5, // Arbitrary value
   parameter int PURST_CYCLES = esap_pkg::PURST_CYC,
   parameter int WC_CYCLES = esap_pkg::WC_CYC
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic wp_i,
   input wire logic address_strap_low_i,
   input wire logic address_strap_high_i,
   output logic rst_active_o,
   output logic standby_o,
   output logic nv_busy_o,
   output logic read_sel_o,
   output logic write_enable_latch_o,
   output logic protect_pin_enable_bit_o,
   output logic [1:0] watchdog_sel_o,
   output logic [1:0] array_protect_o
);
   import esap_pkg::*;

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   function automatic logic addr_match(input logic [7:0] b, input logic [3:0] id,
                                       input logic hi, input logic lo);
      addr_match = (b[7:SA_TYPE_LSB] == id) && !b[SA_ZERO_POS]
                   && (b[SA_SEL_HI_POS] == hi) && (b[SA_SEL_LO_POS] == lo);
   endfunction

   function automatic logic is_locked(input logic [7:0] a, input logic [1:0] bp);
      unique case (bp)
         2'h0: is_locked = 1'b0;
         2'h1: is_locked = (a[7:6] == 2'h3);
         2'h2: is_locked = a[7];
         2'h3: is_locked = 1'b1;
      endcase
   endfunction

   // -------------------------------------------------
   // Link reset release
   // -------------------------------------------------
   // Link logic leaves reset only after two edges of its own clock
   logic [1:0] lrst_ff;

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lrst_ff <= 2'h0;
      end else begin
         lrst_ff <= {lrst_ff[0], 1'b1};
      end
   end

   // -------------------------------------------------
   // Link domain
   // -------------------------------------------------
   esap_link_t lnk_ff, nxt_lnk;
   // System flops are read here only through the link synchronisers
   esap_sys_t sys_ff, nxt_sys;
   logic [7:0] mem [256];
   logic mem_we;
   logic start_c, stop_c, rise_c, fall_c, busy_c, ctrl_blk_c, took_c;

   always_comb begin
      nxt_lnk = lnk_ff;
      mem_we = 1'b0;
      nxt_lnk.scl_p = {lnk_ff.scl_p[0], scl_i};
      nxt_lnk.sda_p = {lnk_ff.sda_p[0], sda_i};
      nxt_lnk.wp_p = {lnk_ff.wp_p[0], wp_i};
      nxt_lnk.s0_p = {lnk_ff.s0_p[0], address_strap_low_i};
      nxt_lnk.s1_p = {lnk_ff.s1_p[0], address_strap_high_i};
      nxt_lnk.rst_p = {lnk_ff.rst_p[0], sys_ff.rst_act};
      nxt_lnk.busy_p = {lnk_ff.busy_p[0], sys_ff.busy};
      nxt_lnk.scl_q = lnk_ff.scl_p[1];
      nxt_lnk.sda_q = lnk_ff.sda_p[1];
      nxt_lnk.busy_q = lnk_ff.busy_p[1];
      start_c = lnk_ff.scl_p[1] && lnk_ff.scl_q && lnk_ff.sda_q && !lnk_ff.sda_p[1];
      stop_c = lnk_ff.scl_p[1] && lnk_ff.scl_q && !lnk_ff.sda_q && lnk_ff.sda_p[1];
      rise_c = lnk_ff.scl_p[1] && !lnk_ff.scl_q;
      fall_c = !lnk_ff.scl_p[1] && lnk_ff.scl_q;
      busy_c = lnk_ff.busy_p[1] || lnk_ff.commit;
      ctrl_blk_c = lnk_ff.wp_p[1] && lnk_ff.cr.pen;
      took_c = 1'b0;

      // The array write lands only when the timed cycle has run out
      if (lnk_ff.commit && lnk_ff.busy_q && !lnk_ff.busy_p[1]) begin
         nxt_lnk.commit = 1'b0;
         if (lnk_ff.wa == CTRL_ADDR) begin
            nxt_lnk.cr.pen = lnk_ff.wd[CR_PEN_POS];
            nxt_lnk.cr.wd = lnk_ff.wd[CR_WD_LSB +: 2];
            nxt_lnk.cr.bp = lnk_ff.wd[CR_BP_LSB +: 2];
         end else begin
            mem_we = 1'b1;
         end
      end

      if (lnk_ff.rst_p[1]) begin
         // Traffic is dropped whole; a cycle already launched still completes
         nxt_lnk.state = ST_IDLE;
         nxt_lnk.oe = 1'b0;
         nxt_lnk.active = 1'b0;
         nxt_lnk.pend = 1'b0;
      end else if (start_c) begin
         nxt_lnk.state = ST_ADDR;
         nxt_lnk.cnt = 4'h0;
         nxt_lnk.oe = 1'b0;
         nxt_lnk.active = 1'b1;
         nxt_lnk.pend = 1'b0;
      end else if (stop_c) begin
         nxt_lnk.state = ST_IDLE;
         nxt_lnk.oe = 1'b0;
         nxt_lnk.active = 1'b0;
         nxt_lnk.pend = 1'b0;
         // The stop's own SCL rise is counted, so a clean stop leaves exactly one
         if (lnk_ff.pend && lnk_ff.state == ST_WDATA && lnk_ff.cnt == 4'h1) begin
            took_c = 1'b1;
         end
      end else if (rise_c) begin
         unique case (lnk_ff.state)
            ST_ADDR, ST_WADDR, ST_WDATA, ST_RDATA: begin
               nxt_lnk.sh = {lnk_ff.sh[6:0], lnk_ff.sda_p[1]};
               nxt_lnk.cnt = lnk_ff.cnt + 4'h1;
            end
            ST_RDATA_ACK: begin
               nxt_lnk.acked = !lnk_ff.sda_p[1];
            end
            default: begin
            end
         endcase
      end else if (fall_c) begin
         unique case (lnk_ff.state)
            ST_ADDR: begin
               if (lnk_ff.cnt == BYTE_BITS) begin
                  nxt_lnk.ok = addr_match(lnk_ff.sh, DEV_TYPE_ID, lnk_ff.s1_p[1],
                                          lnk_ff.s0_p[1]) && !busy_c;
                  nxt_lnk.oe = nxt_lnk.ok;
                  nxt_lnk.rw = lnk_ff.sh[SA_RW_POS];
                  nxt_lnk.state = ST_ADDR_ACK;
               end
            end
            ST_ADDR_ACK: begin
               nxt_lnk.cnt = 4'h0;
               if (!lnk_ff.ok) begin
                  nxt_lnk.oe = 1'b0;
                  nxt_lnk.active = 1'b0;
                  nxt_lnk.state = ST_IGNORE;
               end else if (lnk_ff.rw) begin
                  nxt_lnk.osh = mem[lnk_ff.addr];
                  nxt_lnk.oe = !mem[lnk_ff.addr][7];
                  nxt_lnk.state = ST_RDATA;
               end else begin
                  nxt_lnk.oe = 1'b0;
                  nxt_lnk.state = ST_WADDR;
               end
            end
            ST_WADDR: begin
               if (lnk_ff.cnt == BYTE_BITS) begin
                  nxt_lnk.addr = lnk_ff.sh;
                  nxt_lnk.oe = 1'b1;
                  nxt_lnk.state = ST_WADDR_ACK;
               end
            end
            ST_WADDR_ACK, ST_WDATA_ACK: begin
               nxt_lnk.oe = 1'b0;
               nxt_lnk.cnt = 4'h0;
               nxt_lnk.state = ST_WDATA;
            end
            ST_WDATA: begin
               if (lnk_ff.cnt == BYTE_BITS) begin
                  nxt_lnk.state = ST_WDATA_ACK;
                  if (lnk_ff.addr == CTRL_ADDR) begin
                     nxt_lnk.oe = !ctrl_blk_c;
                     if (!ctrl_blk_c) begin
                        if (lnk_ff.sh == CR_CLR_WEL) begin
                           nxt_lnk.write_enable_latch = 1'b0;
                           nxt_lnk.rwel = 1'b0;
                        end else if (lnk_ff.sh == CR_SET_WEL) begin
                           nxt_lnk.write_enable_latch = 1'b1;
                        end else if (lnk_ff.sh == CR_SET_RWEL && lnk_ff.write_enable_latch) begin
                           nxt_lnk.rwel = 1'b1;
                        end else if (lnk_ff.write_enable_latch && lnk_ff.rwel) begin
                           nxt_lnk.rwel = 1'b0;
                           nxt_lnk.pend = 1'b1;
                           nxt_lnk.wa = lnk_ff.addr;
                           nxt_lnk.wd = lnk_ff.sh;
                        end else begin
                           nxt_lnk.oe = 1'b0;
                        end
                     end
                  end else if (lnk_ff.write_enable_latch && !is_locked(lnk_ff.addr, lnk_ff.cr.bp)) begin
                     nxt_lnk.oe = 1'b1;
                     nxt_lnk.pend = 1'b1;
                     nxt_lnk.wa = lnk_ff.addr;
                     nxt_lnk.wd = lnk_ff.sh;
                     nxt_lnk.addr = lnk_ff.addr + 8'h01;
                  end else begin
                     nxt_lnk.oe = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (lnk_ff.cnt == BYTE_BITS) begin
                  nxt_lnk.oe = 1'b0;
                  nxt_lnk.addr = lnk_ff.addr + 8'h01;
                  nxt_lnk.state = ST_RDATA_ACK;
               end else if (lnk_ff.cnt != 4'h0) begin
                  nxt_lnk.osh = {lnk_ff.osh[6:0], 1'b0};
                  nxt_lnk.oe = !lnk_ff.osh[6];
               end
            end
            ST_RDATA_ACK: begin
               nxt_lnk.cnt = 4'h0;
               if (lnk_ff.acked) begin
                  nxt_lnk.osh = mem[lnk_ff.addr];
                  nxt_lnk.oe = !mem[lnk_ff.addr][7];
                  nxt_lnk.state = ST_RDATA;
               end else begin
                  nxt_lnk.state = ST_IGNORE;
               end
            end
            default: begin
            end
         endcase
      end

      // A stop after a partial byte or before any accepted data launches nothing
      if (took_c) begin
         if (lnk_ff.wa == CTRL_ADDR || !lnk_ff.commit) begin
            nxt_lnk.commit = 1'b1;
            nxt_lnk.launch_tgl = !lnk_ff.launch_tgl;
         end
      end
   end

   always_ff @(posedge link_clk_i or negedge lrst_ff[1]) begin
      if (!lrst_ff[1]) begin
         // Pin samples start at their idle level and bus reset is held, so no false edge
         lnk_ff <= '{state: ST_IDLE, cr: '{pen: 1'b0, wd: CR_RST_WD, bp: CR_RST_BP},
                     scl_p: 2'h3, scl_q: 1'b1, sda_p: 2'h3, sda_q: 1'b1,
                     rst_p: 2'h3, default: '0};
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // Array kept out of the state struct; it is far more than a handful of words
   always_ff @(posedge link_clk_i) begin
      if (mem_we) begin
         mem[lnk_ff.wa] <= lnk_ff.wd;
      end
   end

   // -------------------------------------------------
   // System clock domain
   // -------------------------------------------------
   // Flops of this domain are declared with the link logic, which samples two of them

   always_comb begin
      nxt_sys = sys_ff;
      nxt_sys.launch_p = {sys_ff.launch_p[0], lnk_ff.launch_tgl};
      nxt_sys.launch_q = sys_ff.launch_p[1];
      nxt_sys.act_p = {sys_ff.act_p[0], lnk_ff.active};
      if (sys_ff.rst_act) begin
         if (sys_ff.por_cnt == 32'(PURST_CYCLES - 1)) begin
            nxt_sys.rst_act = 1'b0;
         end else begin
            nxt_sys.por_cnt = sys_ff.por_cnt + 32'h1;
         end
      end
      // A fresh launch restarts the count and wins over the count running out
      if (sys_ff.launch_p[1] != sys_ff.launch_q) begin
         nxt_sys.busy = 1'b1;
         nxt_sys.wc_cnt = 32'h0;
      end else if (sys_ff.busy) begin
         if (sys_ff.wc_cnt == 32'(WC_CYCLES - 1)) begin
            nxt_sys.busy = 1'b0;
         end else begin
            nxt_sys.wc_cnt = sys_ff.wc_cnt + 32'h1;
         end
      end
      // Linger covers the stop-to-busy crossing so standby never blips
      if (sys_ff.act_p[1] || sys_ff.busy) begin
         nxt_sys.lin = 8'(STBY_CYC);
      end else if (sys_ff.lin != 8'h00) begin
         nxt_sys.lin = sys_ff.lin - 8'h01;
      end
      nxt_sys.stby = !(sys_ff.act_p[1] || sys_ff.busy || sys_ff.lin != 8'h00);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_ff <= '{rst_act: 1'b1, stby: 1'b1, default: '0};
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   // -------------------------------------------------
   // Outputs
   // -------------------------------------------------
   // Open-drain data: only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe_o = lnk_ff.oe;
   assign rst_active_o = sys_ff.rst_act;
   assign standby_o = sys_ff.stby;
   assign nv_busy_o = sys_ff.busy;
   assign read_sel_o = lnk_ff.rw;
   assign write_enable_latch_o = lnk_ff.write_enable_latch;
   assign protect_pin_enable_bit_o = lnk_ff.cr.pen;
   assign watchdog_sel_o = lnk_ff.cr.wd;
   assign array_protect_o = lnk_ff.cr.bp;

endmodule

// ---- bench/esap_slave_asserts.sv ----
// Purpose: Port-level assertions for the 2-wire slave front end
// Assumes: Short power-up and write-cycle counts, handed on by the bind
// Notes: Cross-domain checks leave a few cycles of slack for the synchronisers
`timescale 1ns/1ps
module esap_slave_asserts #(
   parameter int PURST_CYCLES = 200,
   parameter int WC_CYCLES = 300
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe_o,
   input wire logic rst_active_o,
   input wire logic standby_o,
   input wire logic nv_busy_o,
   input wire logic read_sel_o,
   input wire logic write_enable_latch_o,
   input wire logic protect_pin_enable_bit_o,
   input wire logic [1:0] watchdog_sel_o,
   input wire logic [1:0] array_protect_o
);
   // ----------------------------------------
   // Saturating counters, so they never wrap
   // ----------------------------------------
   int por_cnt_ff;
   int busy_cnt_ff;
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         por_cnt_ff <= 0;
         busy_cnt_ff <= 0;
      end else begin
         if (por_cnt_ff < PURST_CYCLES + 8) por_cnt_ff <= por_cnt_ff + 1;
         if (!nv_busy_o) busy_cnt_ff <= 0;
         else if (busy_cnt_ff < WC_CYCLES + 16) busy_cnt_ff <= busy_cnt_ff + 1;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_POR_HOLD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      por_cnt_ff < PURST_CYCLES - 2 |-> rst_active_o) else $error("reset output dropped early");
   AST_POR_END: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      por_cnt_ff > PURST_CYCLES + 4 |-> !rst_active_o) else $error("reset output held too long");
   AST_WEL_PUP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      rst_active_o |-> !write_enable_latch_o) else $error("latch set at power-up");
   AST_STBY_PUP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      rst_active_o |-> standby_o) else $error("not in standby at power-up");
   AST_RST_IGNORE: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
      rst_active_o |-> !sda_oe_o ##1 !sda_oe_o) else $error("bus answered during reset");
   AST_CR_PUP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      rst_active_o |-> watchdog_sel_o == 2'h3 && array_protect_o == 2'h0
      && !protect_pin_enable_bit_o) else $error("control bits wrong at power-up");
   AST_WC_BOUND: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      nv_busy_o |-> busy_cnt_ff <= WC_CYCLES + 8) else $error("write cycle too long");
   AST_WC_ACTIVE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      nv_busy_o |-> !standby_o) else $error("standby during write cycle");
   AST_POLL_NACK: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
      nv_busy_o |-> !sda_oe_o) else $error("acknowledge during write cycle");
   AST_LAUNCH_STOP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(nv_busy_o) |-> scl_i && sda_i) else $error("write cycle not launched by stop");
   AST_STBY_FREE: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
      standby_o |-> !sda_oe_o) else $error("data pin driven in standby");
   COV_WC: cover property (@(posedge mclk_i) $rose(nv_busy_o));
   COV_RD: cover property (@(posedge link_clk_i) $rose(read_sel_o));
   COV_BP: cover property (@(posedge mclk_i) array_protect_o == 2'h3);
endmodule
bind esap_slave esap_slave_asserts #(.PURST_CYCLES(PURST_CYCLES), .WC_CYCLES(WC_CYCLES)) u_chk (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_oe_o(sda_oe_o), .rst_active_o(rst_active_o), .standby_o(standby_o),
   .nv_busy_o(nv_busy_o), .read_sel_o(read_sel_o), .write_enable_latch_o(write_enable_latch_o),
   .protect_pin_enable_bit_o(protect_pin_enable_bit_o), .watchdog_sel_o(watchdog_sel_o),
   .array_protect_o(array_protect_o));

// ---- bench/esap_master.sv ----
// Purpose: Behavioural 2-wire bus master
// Assumes: Both lines have pull-ups; the bench resolves the data wire
// Notes: SCL rests high between frames; each phase lasts HALF system clocks
`timescale 1ns/1ps
module esap_master #(
   parameter int HALF = 6
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // One phase: both lines change together just after an edge, then hold
   task automatic step(input logic c, input logic p);
      scl_o <= c;
      sda_pull_o <= p;
      repeat (HALF) @(posedge clk_i);
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start();
      step(scl_o, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic stop();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   // Sampled at the end of the high phase, long after the slave's output delay
   task automatic bit_x(input logic b, output logic s);
      step(1'b0, !b);
      step(1'b1, !b);
      s = sda_i;
      step(1'b0, !b);
   endtask
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'b1, s);
      ack = !s;
   endtask
   task automatic byte_r(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(nack, s);
   endtask
endmodule

// ---- bench/tb_eeprom_slave_address_protect.sv ----
// Purpose: Self-checking bench for the 2-wire slave front end
// Assumes: Short power-up and write-cycle counts
// Notes: All bus traffic goes through the behavioural master model
`timescale 1ns/1ps
module tb_eeprom_slave_address_protect;
   import esap_pkg::*;
   localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary value
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wp = 1'b0;
   logic strap_lo = 1'b1;
   logic strap_hi = 1'b0;
   logic scl, pull, sda_oe, sda_lo, rst_act, stby, busy, rd_sel, write_enable_latch, pen, a;
   logic [1:0] wd, bp;
   logic [7:0] d;
   logic [7:0] bad [4];
   logic [7:0] seq [3];
   int n_fail = 0;
   int num_checks = 0;
   wire sda = !pull && (sda_oe ? sda_lo : 1'b1);
   always #2.5 mclk = ~mclk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   esap_slave #(.DEV_TYPE_ID(TYPE_ID), .PURST_CYCLES(200), .WC_CYCLES(300)) DUT (
      .mclk_i(mclk), .arst_n_i(arst_n), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_lo), .sda_oe_o(sda_oe), .wp_i(wp), .address_strap_low_i(strap_lo),
      .address_strap_high_i(strap_hi), .rst_active_o(rst_act), .standby_o(stby),
      .nv_busy_o(busy), .read_sel_o(rd_sel), .write_enable_latch_o(write_enable_latch),
      .protect_pin_enable_bit_o(pen), .watchdog_sel_o(wd), .array_protect_o(bp));
   esap_master m (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
   task automatic stop_test();
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Type code, zero bit, two select bits, direction last
   function automatic logic [7:0] sa(input logic rw);
      return {TYPE_ID, 1'b0, strap_hi, strap_lo, rw};
   endfunction
   task automatic wr(input logic [7:0] wa, input logic [7:0] dv, output logic ack);
      m.start();
      m.byte_w(sa(1'b0), ack);
      m.byte_w(wa, ack);
      m.byte_w(dv, ack);
      m.stop();
   endtask
   // Bounded wait for the write cycle, then time for standby to return
   task automatic settle();
      repeat (10) @(posedge mclk);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
      chk({7'h0, busy}, 8'h00);
      repeat (80) @(posedge mclk);
   endtask
   initial begin
      bad = '{sa(1'b0) ^ 8'h80, sa(1'b0) | 8'h08, sa(1'b0) ^ 8'h04, sa(1'b0) ^ 8'h02};
      seq = '{CR_SET_WEL, CR_SET_RWEL, 8'h98};
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      chk({4'h0, rst_act, stby, sda_oe, write_enable_latch}, 8'h0C);
      chk({3'h0, pen, wd, bp}, 8'h0C);
      m.start();
      m.byte_w(sa(1'b0), a);
      chk({7'h0, a}, 8'h00);
      m.stop();
      for (int i = 0; i < 1000 && rst_act !== 1'b0; i++) @(posedge mclk);
      chk({7'h0, rst_act}, 8'h00);
      repeat (10) @(posedge mclk);
      foreach (bad[i]) begin
         m.start();
         m.byte_w(bad[i], a);
         repeat (60) @(posedge mclk);
         chk({6'h0, a, stby}, 8'h01);
         m.stop();
         settle();
      end
      wr(8'h10, 8'hA5, a);
      chk({7'h0, a}, 8'h00);
      settle();
      wr(CTRL_ADDR, CR_SET_WEL, a);
      settle();
      chk({6'h0, a, write_enable_latch}, 8'h03);
      wr(8'h10, 8'hA5, a);
      repeat (4) @(posedge mclk);
      chk({6'h0, a, busy}, 8'h03);
      m.start();
      m.byte_w(sa(1'b0), a);
      chk({6'h0, a, busy}, 8'h01);
      m.stop();
      settle();
      m.start();
      m.byte_w(sa(1'b0), a);
      m.byte_w(8'h10, a);
      chk({5'h0, a, rd_sel, stby}, 8'h04);
      m.start();
      m.byte_w(sa(1'b1), a);
      m.byte_r(1'b1, d);
      chk({7'h0, rd_sel}, 8'h01);
      chk(d, 8'hA5);
      m.stop();
      settle();
      chk({7'h0, stby}, 8'h01);
      // A stop in mid-byte must not launch a write cycle
      m.start();
      m.byte_w(sa(1'b0), a);
      m.byte_w(8'h20, a);
      m.byte_w(8'h33, a);
      chk({7'h0, a}, 8'h01);
      for (int i = 0; i < 4; i++) m.bit_x(1'b1, a);
      m.stop();
      repeat (20) @(posedge mclk);
      chk({7'h0, busy}, 8'h00);
      settle();
      wr(CTRL_ADDR, 8'h18, a);
      settle();
      chk({6'h0, bp}, 8'h00);
      foreach (seq[i]) begin
         wr(CTRL_ADDR, seq[i], a);
         settle();
      end
      chk({3'h0, pen, wd, bp}, 8'h13);
      wr(CTRL_ADDR, CR_SET_WEL, a);
      settle();
      wr(8'h10, 8'h5A, a);
      chk({7'h0, a}, 8'h00);
      settle();
      wp <= 1'b1;
      wr(CTRL_ADDR, CR_SET_WEL, a);
      chk({7'h0, a}, 8'h00);
      settle();
      stop_test();
   end
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
endmodule
